// ===== include/rsg_pkg.sv
// Purpose: constants, codes and types shared by the reset source guard
// Assumes: 200 MHz clock, 32-bit APB with byte addresses
// Notes:   register offsets are local choices, see hand-over
package rsg_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS       = 5;
    localparam int GUARD_DELAY_NS      = 10000;
    localparam int LOW_FILTER_NS       = 15000;
    localparam int GUARD_DELAY_CYCLES  =
        (GUARD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOW_FILTER_CYCLES   =
        (LOW_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W             = 16;

    // register byte offsets
    localparam logic [7:0] OFS_GUARD   = 8'h00;
    localparam logic [7:0] OFS_CAUSE   = 8'h04;
    localparam logic [7:0] OFS_LEVEL   = 8'h08;
    localparam logic [7:0] OFS_FLASH   = 8'h0C;
    localparam logic [7:0] OFS_WDCTRL  = 8'h10;
    localparam logic [7:0] OFS_STATUS  = 8'h14;

    // reset values
    localparam logic [7:0] GUARD_RST   = 8'h55;
    localparam logic [7:0] LEVEL_RST   = 8'h55;
    localparam logic [7:0] WDCTRL_RST  = 8'h53;
    localparam logic [7:0] FLASH_RST   = 8'h00;

    // codes
    localparam logic [7:0] GUARD_OK_A  = 8'h55;
    localparam logic [7:0] GUARD_OK_B  = 8'hAA;
    localparam logic [7:0] LEVEL_CODE0 = 8'h55;
    localparam logic [7:0] LEVEL_CODE1 = 8'h33;
    localparam logic [7:0] LEVEL_CODE2 = 8'h99;
    localparam logic [7:0] LEVEL_CODE3 = 8'hAA;
    localparam logic [4:0] WD_EN_A     = 5'h0A;
    localparam logic [4:0] WD_EN_B     = 5'h15;
    localparam logic [7:0] FLASH_RESET = 8'h55;

    // field positions
    localparam int CAUSE_GUARD_BIT     = 3;
    localparam int CAUSE_LOW_BIT       = 2;
    localparam int CAUSE_LEVEL_BIT     = 1;
    localparam int CAUSE_WDCTRL_BIT    = 0;
    localparam int STAT_EXPIRED_BIT    = 0;
    localparam int STAT_PDOWN_BIT      = 1;
    localparam int WD_EN_LSB           = 3;

    // pending guard-delay sources
    localparam int SRC_GUARD           = 0;
    localparam int SRC_LEVEL           = 1;
    localparam int SRC_WDCTRL          = 2;
    localparam int SRC_N               = 3;

    typedef enum logic [1:0] {MODE_FAST, MODE_SLOW, MODE_IDLE, MODE_SLEEP}
        rsg_mode_type;

    function automatic logic level_valid(input logic [7:0] v);
        return (v == LEVEL_CODE0) || (v == LEVEL_CODE1) ||
               (v == LEVEL_CODE2) || (v == LEVEL_CODE3);
    endfunction

    function automatic logic [1:0] level_index(input logic [7:0] v);
        logic [1:0] idx;
        idx = 2'h0;
        if (v == LEVEL_CODE1)
            idx = 2'h1;
        else if (v == LEVEL_CODE2)
            idx = 2'h2;
        else if (v == LEVEL_CODE3)
            idx = 2'h3;
        return idx;
    endfunction

endpackage

// ===== hdl/rsg_sync.sv
// Purpose: two-flop synchroniser for an asynchronous level
// Assumes: input may change at any time
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module rsg_sync
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // level
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_q;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_q   <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule
`default_nettype wire

// ===== hdl/rsg_timer.sv
// Purpose: run-length timer, pulses done after LIMIT+1 cycles of run
// Assumes: run drops or stays; count restarts whenever run is low
// Notes:   wraps to zero on done, so a held run repeats every LIMIT+1
`timescale 1ns/1ps
`default_nettype none
module rsg_timer
#(
    parameter int LIMIT = 16
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // control
    input  wire logic run,
    output logic      done
);

    logic [rsg_pkg::TIMER_W-1:0] cnt_q;
    localparam logic [rsg_pkg::TIMER_W-1:0] LIM =
        rsg_pkg::TIMER_W'(LIMIT);

    assign done = run && (cnt_q == LIM);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            cnt_q <= '0;
        else if (!run || done)
            cnt_q <= '0;
        else
            cnt_q <= cnt_q + 1'b1;
    end

endmodule
`default_nettype wire

// ===== hdl/rsg_reset_source_guard.sv
// Purpose: reset source guard with APB register access
// Assumes: mode and watchdog time-out come from this clock domain;
//          the low-supply comparator output is asynchronous
// Notes:   reset requests are one-cycle pulses; flags survive them
// Behaviour
// - guard codes 55/AA idle, others delayed reset
// - guard reset sets cause bit 3
// - guard flag cleared only by software zero
// - cause bits 7 to 4 read zero
// - low-supply monitor only in fast/slow
// - low-supply reset only after filter time
// - low-supply reset sets cause bit 2
// - decode four level codes into thresholds
// - bad level code: delayed reset, restore
// - bad level code sets cause bit 1
// - low-supply reset keeps level register
// - bits 2 and 1 cleared by software
// - level register powers up as 55
// - flash command 55 resets device
// - watchdog time-out in fast/slow sets expired
// - sleep/idle time-out clears pc, sp only
// - bad watchdog enable sets cause bit 0
// - guard register powers up as 55
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module rsg_reset_source_guard
#(
    parameter int GUARD_CYCLES  = rsg_pkg::GUARD_DELAY_CYCLES,
    parameter int FILTER_CYCLES = rsg_pkg::LOW_FILTER_CYCLES
)
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rstn,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // device state
    input  wire rsg_pkg::rsg_mode_type power_mode,
    input  wire logic                low_supply_det,
    input  wire logic                watchdog_timeout,
    // reset and control outputs
    output logic                     device_reset,
    output logic                     pc_sp_clear,
    output logic      [1:0]          low_supply_threshold,
    output logic                     low_supply_monitor_en,
    output logic                     watchdog_enable
);

    logic [7:0]           guard_q;
    logic [7:0]           level_q;
    logic [7:0]           wdctrl_q;
    logic [7:0]           flash_q;
    logic [3:0]           cause_q;
    logic [1:0]           status_q;
    logic [rsg_pkg::SRC_N-1:0] pend_q;
    logic [rsg_pkg::SRC_N-1:0] bad;
    logic                 low_sync;
    logic                 guard_done;
    logic                 filter_done;
    logic                 wr_en;
    logic                 rd_setup;
    logic                 mapped;
    logic                 run_mode;
    logic                 flash_cmd;
    logic                 wdt_reset;
    logic                 wdt_light;
    logic [31:0]          rd_d;

    // zero wait states; access phase is always the answer
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;

    always_comb
    begin
        unique case (paddr)
            rsg_pkg::OFS_GUARD,
            rsg_pkg::OFS_CAUSE,
            rsg_pkg::OFS_LEVEL,
            rsg_pkg::OFS_FLASH,
            rsg_pkg::OFS_WDCTRL,
            rsg_pkg::OFS_STATUS: mapped = 1'b1;
            default:             mapped = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !mapped;

    always_comb
    begin
        rd_d = 32'h0000_0000;
        unique case (paddr)
            rsg_pkg::OFS_GUARD:  rd_d[7:0] = guard_q;
            rsg_pkg::OFS_CAUSE:  rd_d[3:0] = cause_q;
            rsg_pkg::OFS_LEVEL:  rd_d[7:0] = level_q;
            rsg_pkg::OFS_FLASH:  rd_d[7:0] = flash_q;
            rsg_pkg::OFS_WDCTRL: rd_d[7:0] = wdctrl_q;
            rsg_pkg::OFS_STATUS: rd_d[1:0] = status_q;
            default:             rd_d      = 32'h0000_0000;
        endcase
    end

    // read data captured in setup so it stands through the access
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            prdata <= 32'h0000_0000;
        else if (rd_setup)
            prdata <= rd_d;
    end

    // pattern checks on the noise-protected registers
    assign bad[rsg_pkg::SRC_GUARD] =
        (guard_q != rsg_pkg::GUARD_OK_A) &&
        (guard_q != rsg_pkg::GUARD_OK_B);
    assign bad[rsg_pkg::SRC_LEVEL] = !rsg_pkg::level_valid(level_q);
    assign bad[rsg_pkg::SRC_WDCTRL] =
        (wdctrl_q[7:3] != rsg_pkg::WD_EN_A) &&
        (wdctrl_q[7:3] != rsg_pkg::WD_EN_B);

    assign watchdog_enable      = !bad[rsg_pkg::SRC_WDCTRL];
    assign low_supply_threshold = rsg_pkg::level_index(level_q);

    // once latched, a source stays pending until the delay expires,
    // even if software repairs the register meanwhile
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            pend_q <= '0;
        else if (guard_done)
            pend_q <= '0;
        else
            pend_q <= pend_q | bad;
    end

    rsg_timer #(
        .LIMIT (GUARD_CYCLES)
    ) u_guard_timer (
        .clk   (clk),
        .rstn  (rstn),
        .run   (|pend_q),
        .done  (guard_done)
    );

    // low-supply path
    rsg_sync u_low_sync (
        .clk      (clk),
        .rstn     (rstn),
        .async_in (low_supply_det),
        .sync_out (low_sync)
    );

    assign run_mode = (power_mode == rsg_pkg::MODE_FAST) ||
                      (power_mode == rsg_pkg::MODE_SLOW);
    // a bad level code is handled by the guard delay instead
    assign low_supply_monitor_en = run_mode &&
                                   rsg_pkg::level_valid(level_q);

    rsg_timer #(
        .LIMIT (FILTER_CYCLES)
    ) u_filter_timer (
        .clk   (clk),
        .rstn  (rstn),
        .run   (low_supply_monitor_en && low_sync),
        .done  (filter_done)
    );

    // other reset sources
    assign flash_cmd = wr_en && (paddr == rsg_pkg::OFS_FLASH) &&
                       (pwdata[7:0] == rsg_pkg::FLASH_RESET);
    assign wdt_reset = watchdog_timeout && run_mode;
    assign wdt_light = watchdog_timeout && !run_mode;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            device_reset <= 1'b0;
            pc_sp_clear  <= 1'b0;
        end
        else
        begin
            device_reset <= guard_done || filter_done ||
                            flash_cmd || wdt_reset;
            pc_sp_clear  <= wdt_light;
        end
    end

    // reset guard register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            guard_q <= rsg_pkg::GUARD_RST;
        else if (guard_done && pend_q[rsg_pkg::SRC_GUARD])
            guard_q <= rsg_pkg::GUARD_RST;
        else if (wr_en && paddr == rsg_pkg::OFS_GUARD)
            guard_q <= pwdata[7:0];
    end

    // level select; a low-supply reset leaves it untouched
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            level_q <= rsg_pkg::LEVEL_RST;
        else if (guard_done && pend_q[rsg_pkg::SRC_LEVEL])
            level_q <= rsg_pkg::LEVEL_RST;
        else if (wr_en && paddr == rsg_pkg::OFS_LEVEL)
            level_q <= pwdata[7:0];
    end

    // watchdog control
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            wdctrl_q <= rsg_pkg::WDCTRL_RST;
        else if (guard_done && pend_q[rsg_pkg::SRC_WDCTRL])
            wdctrl_q <= rsg_pkg::WDCTRL_RST;
        else if (wr_en && paddr == rsg_pkg::OFS_WDCTRL)
            wdctrl_q <= pwdata[7:0];
    end

    // flash command holds last value written
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            flash_q <= rsg_pkg::FLASH_RST;
        else if (wr_en && paddr == rsg_pkg::OFS_FLASH)
            flash_q <= pwdata[7:0];
    end

    // cause flags: write zero clears, hardware set wins
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            cause_q <= 4'h0;
        else
        begin
            if (wr_en && paddr == rsg_pkg::OFS_CAUSE)
                cause_q <= cause_q & pwdata[3:0];
            if (guard_done && pend_q[rsg_pkg::SRC_GUARD])
                cause_q[rsg_pkg::CAUSE_GUARD_BIT] <= 1'b1;
            if (filter_done)
                cause_q[rsg_pkg::CAUSE_LOW_BIT] <= 1'b1;
            if (guard_done && pend_q[rsg_pkg::SRC_LEVEL])
                cause_q[rsg_pkg::CAUSE_LEVEL_BIT] <= 1'b1;
            if (guard_done && pend_q[rsg_pkg::SRC_WDCTRL])
                cause_q[rsg_pkg::CAUSE_WDCTRL_BIT] <= 1'b1;
        end
    end

    // status: expired and powerdown flags
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            status_q <= 2'h0;
        else
        begin
            if (wr_en && paddr == rsg_pkg::OFS_STATUS)
                status_q <= status_q & pwdata[1:0];
            if (watchdog_timeout)
                status_q[rsg_pkg::STAT_EXPIRED_BIT] <= 1'b1;
            if (wdt_light)
                status_q[rsg_pkg::STAT_PDOWN_BIT] <= 1'b1;
        end
    end

endmodule
`default_nettype wire

// ===== testbench/rsg_guard_props.sv
// Purpose: concurrent checks on the reset source guard ports
// Assumes: one clock, rstn asynchronous active low
// Notes:   delay bounds leave margin over the timer latency
`timescale 1ns/1ps
`default_nettype none
module rsg_guard_props
#(
    parameter int GUARD_CYCLES  = 4,
    parameter int FILTER_CYCLES = 6
)
(
    // clock and reset
    input wire logic                  clk,
    input wire logic                  rstn,
    // apb
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [7:0]            paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    // device side
    input wire rsg_pkg::rsg_mode_type power_mode,
    input wire logic                  low_supply_det,
    input wire logic                  watchdog_timeout,
    input wire logic                  device_reset,
    input wire logic                  pc_sp_clear,
    input wire logic [1:0]            low_supply_threshold,
    input wire logic                  low_supply_monitor_en
);
    localparam int GMAX = GUARD_CYCLES + 8;
    localparam int FLIM = FILTER_CYCLES + 6;
    logic        wr;
    logic        wr_lvl;
    logic        run;
    logic [15:0] low_cnt_q;
    logic        seen_q;
    assign wr = psel && penable && pwrite;
    assign wr_lvl = wr && paddr == 8'h08;
    assign run = power_mode == rsg_pkg::MODE_FAST ||
                 power_mode == rsg_pkg::MODE_SLOW;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // length of the current low-supply streak, and whether it reset
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            low_cnt_q <= 16'h0000;
            seen_q    <= 1'b0;
        end
        else if (!(low_supply_det && low_supply_monitor_en))
        begin
            low_cnt_q <= 16'h0000;
            seen_q    <= 1'b0;
        end
        else
        begin
            low_cnt_q <= low_cnt_q + 16'h0001;
            seen_q    <= seen_q || device_reset;
        end
    end
    AST_GUARD_DELAY: assert property (
        wr && paddr == 8'h00 && !(pwdata[7:0] inside {8'h55, 8'hAA})
        |-> ##[1:GMAX] device_reset) else $error("guard fault not reset");
    AST_LEVEL_DELAY: assert property (
        wr_lvl && !(pwdata[7:0] inside {8'h55, 8'h33, 8'h99, 8'hAA})
        |-> ##[1:GMAX] (device_reset && low_supply_threshold == 2'h0 &&
                        (low_supply_monitor_en || !run)))
        else $error("level fault not reset or restored");
    AST_LOW_FILTER: assert property (
        low_cnt_q == FLIM[15:0] |-> seen_q || device_reset)
        else $error("held low supply gave no reset");
    AST_FLASH_RESET: assert property (
        wr && paddr == 8'h0C && pwdata[7:0] == 8'h55 |=> device_reset)
        else $error("flash command gave no reset");
    AST_WD_RUN: assert property (
        watchdog_timeout && run |=> device_reset && !pc_sp_clear)
        else $error("run mode time-out wrong");
    AST_WD_SLEEP: assert property (
        watchdog_timeout && !run |=> pc_sp_clear && !device_reset)
        else $error("sleep mode time-out wrong");
    AST_MON_OFF: assert property (
        !run |-> !low_supply_monitor_en)
        else $error("monitor on in sleep or idle");
    AST_CAUSE_UPPER: assert property (
        psel && penable && !pwrite && paddr == 8'h04
        |-> prdata[31:4] == 28'h0) else $error("cause upper bits set");
    AST_THRESH_HOLD: assert property (
        !$stable(low_supply_threshold) |-> device_reset || $past(wr_lvl))
        else $error("threshold changed without cause");
    cover property (device_reset);
    cover property (pc_sp_clear);
    cover property (low_cnt_q == FLIM[15:0]);
endmodule
bind rsg_reset_source_guard rsg_guard_props #(
    .GUARD_CYCLES(GUARD_CYCLES),
    .FILTER_CYCLES(FILTER_CYCLES)
) u_props (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .power_mode, .low_supply_det, .watchdog_timeout,
    .device_reset, .pc_sp_clear, .low_supply_threshold,
    .low_supply_monitor_en);
`default_nettype wire

// ===== testbench/rsg_reset_source_guard_bench.sv
// Purpose: directed register and reset-source tests over APB
// Assumes: short guard and filter counts for run time
// Notes:   reset pulses are searched for in bounded windows
`timescale 1ns/1ps
`default_nettype none
module rsg_reset_source_guard_bench;
    localparam int G = 4;
    localparam int F = 6;
    localparam logic [7:0] LC [4] = '{8'h55, 8'h33, 8'h99, 8'hAA};
    logic        clk, rstn, psel, penable, pwrite, pready, pslverr, lerr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic        low_supply_det, watchdog_timeout, device_reset;
    logic        pc_sp_clear, low_supply_monitor_en, watchdog_enable;
    logic [1:0]  low_supply_threshold;
    rsg_pkg::rsg_mode_type power_mode;
    int          failures, samples_checked;
    rsg_reset_source_guard #(.GUARD_CYCLES(G), .FILTER_CYCLES(F)) dut (
        .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .power_mode, .low_supply_det, .watchdog_timeout,
        .device_reset, .pc_sp_clear, .low_supply_threshold,
        .low_supply_monitor_en, .watchdog_enable);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // no wait-state count assumed; the bench timeout ends a hang
        while (pready !== 1'b1)
            @(posedge clk);
        rdat = prdata;
        lerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    // records whether either reset output pulsed within n cycles
    task automatic watch(input int n, input logic dr, input logic pc);
        logic sd, sp;
        sd = 1'b0;
        sp = 1'b0;
        repeat (n)
        begin
            @(posedge clk);
            sd = sd | device_reset;
            sp = sp | pc_sp_clear;
        end
        chk({30'h0, sd, sp}, {30'h0, dr, pc});
    endtask
    task automatic wdp();
        @(posedge clk);
        watchdog_timeout <= 1'b1;
        @(posedge clk);
        watchdog_timeout <= 1'b0;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // whole run needs a few hundred cycles
    initial
    begin
        #100us;
        failures++;
        summarize();
    end
    initial
    begin
        {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
        {low_supply_det, watchdog_timeout, failures, samples_checked} = '0;
        power_mode = rsg_pkg::MODE_FAST;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        rd(8'h00, 32'h55);
        rd(8'h08, 32'h55);
        rd(8'h04, 32'h00);
        chk({31'h0, lerr}, 32'h0);
        $display("reset values done");
        for (int i = 0; i < 4; i++)
        begin
            xfer(1'b1, 8'h08, {24'h0, LC[i]});
            rd(8'h08, {24'h0, LC[i]});
            chk({30'h0, low_supply_threshold}, i);
        end
        watch(G + 10, 1'b0, 1'b0);
        xfer(1'b1, 8'h00, 32'hAA);
        watch(G + 10, 1'b0, 1'b0);
        xfer(1'b1, 8'h00, 32'h12);
        xfer(1'b1, 8'h00, 32'h55);
        watch(G + 10, 1'b1, 1'b0);
        rd(8'h04, 32'h08);
        xfer(1'b1, 8'h0C, 32'h55);
        watch(3, 1'b1, 1'b0);
        xfer(1'b1, 8'h04, 32'hFF);
        rd(8'h04, 32'h08);
        xfer(1'b1, 8'h04, 32'h00);
        rd(8'h04, 32'h00);
        $display("guard and flash done");
        xfer(1'b1, 8'h08, 32'h12);
        watch(G + 10, 1'b1, 1'b0);
        rd(8'h08, 32'h55);
        rd(8'h04, 32'h02);
        xfer(1'b1, 8'h04, 32'h00);
        rd(8'h04, 32'h00);
        $display("level fault done");
        xfer(1'b1, 8'h08, 32'hAA);
        low_supply_det <= 1'b1;
        repeat (4) @(posedge clk);
        low_supply_det <= 1'b0;
        watch(F + 12, 1'b0, 1'b0);
        low_supply_det <= 1'b1;
        watch(F + 8, 1'b1, 1'b0);
        low_supply_det <= 1'b0;
        rd(8'h04, 32'h04);
        rd(8'h08, 32'hAA);
        power_mode     <= rsg_pkg::MODE_SLEEP;
        low_supply_det <= 1'b1;
        watch(F + 12, 1'b0, 1'b0);
        chk({31'h0, low_supply_monitor_en}, 32'h0);
        low_supply_det <= 1'b0;
        xfer(1'b1, 8'h04, 32'h00);
        rd(8'h04, 32'h00);
        $display("low supply done");
        power_mode <= rsg_pkg::MODE_SLOW;
        wdp();
        watch(3, 1'b1, 1'b0);
        rd(8'h14, 32'h01);
        xfer(1'b1, 8'h14, 32'h00);
        power_mode <= rsg_pkg::MODE_IDLE;
        wdp();
        watch(3, 1'b0, 1'b1);
        rd(8'h14, 32'h03);
        rd(8'h08, 32'hAA);
        power_mode <= rsg_pkg::MODE_FAST;
        $display("watchdog time-out done");
        xfer(1'b1, 8'h10, 32'hAB);
        watch(G + 10, 1'b0, 1'b0);
        chk({31'h0, watchdog_enable}, 32'h1);
        xfer(1'b1, 8'h10, 32'h03);
        watch(G + 10, 1'b1, 1'b0);
        rd(8'h04, 32'h01);
        rd(8'h10, 32'h53);
        chk({31'h0, watchdog_enable}, 32'h1);
        rd(8'h20, 32'h00);
        chk({31'h0, lerr}, 32'h1);
        $display("watchdog control and unmapped done");
        summarize();
    end
endmodule
`default_nettype wire
